/* File: common/trim_bank_pkg.sv */
// constants for the calibration trim register bank
package trim_bank_pkg;
    // register pointers
    localparam logic [7:0] REG_CELL2_TRIM     = 8'h12;
    localparam logic [7:0] REG_CELL3_TRIM     = 8'h13;
    localparam logic [7:0] REG_CELL4_TRIM     = 8'h14;
    localparam logic [7:0] REG_CELL5_TRIM     = 8'h15;
    localparam logic [7:0] REG_CELL6_TRIM     = 8'h16;
    localparam logic [7:0] REG_CELLS_1_2_MSBS = 8'h17;
    localparam logic [7:0] REG_CELLS_3_6_MSBS = 8'h18;
    localparam logic [7:0] REG_REF_MSBS       = 8'h1B;
    // value read from an unmapped pointer or unassigned bits
    localparam logic [7:0] UNMAPPED_VALUE     = 8'h00;
    // field layout of a cell trim byte
    localparam int         OFFSET_LOW_POS     = 4;
    localparam int         GAIN_LOW_POS       = 0;
    localparam int         LOW_WIDTH          = 4;
    // number of cells whose low bits live in this bank (cells 2..6)
    localparam int         LOW_CELLS          = 5;
    localparam int         ALL_CELLS          = 6;
    // crc of the read answer
    localparam logic [7:0] CRC_INIT           = 8'h00;
    // i2c framing
    localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
    localparam logic [3:0] LAST_BIT_INDEX     = 4'h7;
    // reset values
    localparam logic [7:0] PTR_RESET          = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_TX,
        ST_HOST_ACK
    } link_state_t;
endpackage

/* File: hw/calibration_trim_register_bank.sv */
// calibration trim register bank behind an i2c register port
// Notes on behaviour
// - cells 2-6 trim byte: offset low nibble high, gain low nibble low.
// - first extension byte bits 7..4: offset1, gain1, offset2, gain2 msbs.
// - second extension byte: offset/gain msb pairs for cells 3..6 downward.
// - reference extension: offset bit5 at 2, bit4 at 1, gain msb at 0.
// - read answer offers crc byte after data; host may nack and stop.
`timescale 1ns/1ps
`default_nettype none
module calibration_trim_register_bank
    import trim_bank_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h08, // arbitrary bus address
    parameter logic [7:0] CRC_POLY    = 8'h07
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rstn,
    // i2c pins
    input  wire logic                           scl,
    input  wire logic                           sda_in,
    output var  logic                           sda_out,
    output var  logic                           sda_oe,
    // factory programmed trim image
    input  wire logic [LOW_CELLS*LOW_WIDTH-1:0] offset_low_in,
    input  wire logic [LOW_CELLS*LOW_WIDTH-1:0] gain_low_in,
    input  wire logic [ALL_CELLS-1:0]           offset_msb_in,
    input  wire logic [ALL_CELLS-1:0]           gain_msb_in,
    input  wire logic                           reference_offset_bit5,
    input  wire logic                           reference_offset_bit4,
    input  wire logic                           reference_gain_msb
);

    link_state_t state_q;
    logic        scl_q;
    logic        sda_q;
    logic [7:0]  rx_q;
    logic [3:0]  cnt_q;
    logic        rw_q;
    logic        ack_q;
    logic        crc_sent_q;
    logic        ptr_loaded_q;
    logic [7:0]  ptr_q;
    logic [7:0]  tx_byte_q;
    logic [7:0]  crc_q;
    logic        sda_oe_q;
    logic        start_ev;
    logic        stop_ev;
    logic        scl_rise;
    logic        scl_fall;
    logic [7:0]  read_value;
    logic [7:0]  answer_crc;

    // byte presented for a register pointer
    function automatic logic [7:0] reg_value(input logic [7:0] ptr);
        logic [7:0] v;
        int         idx;
        v   = UNMAPPED_VALUE;
        idx = 0;
        if (ptr >= REG_CELL2_TRIM && ptr <= REG_CELL6_TRIM) begin
            idx = int'(ptr - REG_CELL2_TRIM);
            v[OFFSET_LOW_POS +: LOW_WIDTH] = offset_low_in[idx*LOW_WIDTH +: LOW_WIDTH];
            v[GAIN_LOW_POS +: LOW_WIDTH]   = gain_low_in[idx*LOW_WIDTH +: LOW_WIDTH];
        end else if (ptr == REG_CELLS_1_2_MSBS) begin
            v = {offset_msb_in[0], gain_msb_in[0], offset_msb_in[1], gain_msb_in[1],
                 4'h0};
        end else if (ptr == REG_CELLS_3_6_MSBS) begin
            v = {offset_msb_in[2], gain_msb_in[2], offset_msb_in[3], gain_msb_in[3],
                 offset_msb_in[4], gain_msb_in[4], offset_msb_in[5], gain_msb_in[5]};
        end else if (ptr == REG_REF_MSBS) begin
            v = {5'h00, reference_offset_bit5, reference_offset_bit4,
                 reference_gain_msb};
        end
        return v;
    endfunction

    // one byte step of the answer crc, msb first
    function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // bus conditions from the previous pin sample
    always_comb begin
        start_ev   = scl && scl_q && sda_q && !sda_in;
        stop_ev    = scl && scl_q && !sda_q && sda_in;
        scl_rise   = scl && !scl_q;
        scl_fall   = !scl && scl_q;
        read_value = reg_value(ptr_q);
        answer_crc = crc8(crc8(CRC_INIT, rx_q), read_value);
    end

    // previous pin levels
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // register pointer, taken from the first byte after a write address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q        <= PTR_RESET;
            ptr_loaded_q <= 1'b0;
        end else if (start_ev) begin
            ptr_loaded_q <= 1'b0;
        end else if (state_q == ST_PTR && scl_fall && cnt_q == BITS_PER_BYTE) begin
            if (!ptr_loaded_q) begin
                ptr_q <= rx_q;
            end
            ptr_loaded_q <= 1'b1;
        end
    end

    // answer crc over read address byte and data byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_q <= CRC_INIT;
        end else if (state_q == ST_ADDR_ACK && scl_fall && rw_q) begin
            crc_q <= answer_crc;
        end
    end

    // link state machine and sda drive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= ST_IDLE;
            rx_q       <= 8'h00;
            cnt_q      <= 4'h0;
            rw_q       <= 1'b0;
            ack_q      <= 1'b0;
            crc_sent_q <= 1'b0;
            tx_byte_q  <= 8'h00;
            sda_oe_q   <= 1'b0;
        end else if (start_ev) begin
            state_q    <= ST_ADDR;
            cnt_q      <= 4'h0;
            crc_sent_q <= 1'b0;
            sda_oe_q   <= 1'b0;
        end else if (stop_ev) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else if (scl_rise) begin
            if (state_q == ST_ADDR || state_q == ST_PTR) begin
                rx_q  <= {rx_q[6:0], sda_in};
                cnt_q <= cnt_q + 4'h1;
            end else if (state_q == ST_HOST_ACK) begin
                ack_q <= !sda_in;
            end
        end else if (scl_fall) begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ST_ADDR: begin
                    if (cnt_q == BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        if (rx_q[7:1] == DEVICE_ADDR) begin
                            rw_q     <= rx_q[0];
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_ADDR_ACK;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (rw_q) begin
                        tx_byte_q <= read_value;
                        sda_oe_q  <= !read_value[7];
                        cnt_q     <= 4'h1;
                        state_q   <= ST_TX;
                    end else begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (cnt_q == BITS_PER_BYTE) begin
                        cnt_q    <= 4'h0;
                        sda_oe_q <= 1'b1;
                        state_q  <= ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK: begin
                    sda_oe_q <= 1'b0;
                    state_q  <= ST_PTR;
                end
                ST_TX: begin
                    if (cnt_q == BITS_PER_BYTE) begin
                        cnt_q    <= 4'h0;
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_HOST_ACK;
                    end else begin
                        sda_oe_q <= !tx_byte_q[3'(LAST_BIT_INDEX - cnt_q)];
                        cnt_q    <= cnt_q + 4'h1;
                    end
                end
                ST_HOST_ACK: begin
                    if (ack_q && !crc_sent_q) begin
                        tx_byte_q  <= crc_q;
                        sda_oe_q   <= !crc_q[7];
                        crc_sent_q <= 1'b1;
                        cnt_q      <= 4'h1;
                        state_q    <= ST_TX;
                    end else begin
                        sda_oe_q <= 1'b0;
                        state_q  <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // pins: open drain, only ever pulls low
    assign sda_oe = sda_oe_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    logic data_load;
    assign data_load = state_q == ST_ADDR_ACK && scl_fall && rw_q && !start_ev && !stop_ev;

    a_cell_trim_byte: assert property (@(posedge clk) disable iff (!rstn)
        data_load && ptr_q == REG_CELL4_TRIM |=>
        tx_byte_q == {$past(offset_low_in[11:8]), $past(gain_low_in[11:8])})
        else $error("cell trim byte layout wrong");
    a_first_ext_byte: assert property (@(posedge clk) disable iff (!rstn)
        data_load && ptr_q == REG_CELLS_1_2_MSBS |=>
        tx_byte_q[7:4] == {$past(offset_msb_in[0]), $past(gain_msb_in[0]),
                           $past(offset_msb_in[1]), $past(gain_msb_in[1])})
        else $error("first extension byte wrong");
    a_second_ext_byte: assert property (@(posedge clk) disable iff (!rstn)
        data_load && ptr_q == REG_CELLS_3_6_MSBS |=>
        tx_byte_q[1:0] == {$past(offset_msb_in[5]), $past(gain_msb_in[5])} &&
        tx_byte_q[7:6] == {$past(offset_msb_in[2]), $past(gain_msb_in[2])})
        else $error("second extension byte wrong");
    a_ref_ext_byte: assert property (@(posedge clk) disable iff (!rstn)
        data_load && ptr_q == REG_REF_MSBS |=>
        tx_byte_q == {5'h00, $past(reference_offset_bit5), $past(reference_offset_bit4),
                      $past(reference_gain_msb)})
        else $error("reference extension byte wrong");
    a_crc_follows: assert property (@(posedge clk) disable iff (!rstn)
        state_q == ST_HOST_ACK && scl_fall && ack_q && !crc_sent_q && !start_ev && !stop_ev
        |=> state_q == ST_TX && tx_byte_q == $past(crc_q) && crc_sent_q)
        else $error("crc byte not offered after data");
    a_nack_ends: assert property (@(posedge clk) disable iff (!rstn)
        state_q == ST_HOST_ACK && scl_fall && !ack_q && !start_ev && !stop_ev
        |=> state_q == ST_IDLE && !sda_oe)
        else $error("bus not released after nack");

    c_data_read: cover property (@(posedge clk) disable iff (!rstn) data_load);
    c_crc_sent: cover property (@(posedge clk) disable iff (!rstn)
        $rose(crc_sent_q));
    c_ptr_write: cover property (@(posedge clk) disable iff (!rstn)
        $rose(ptr_loaded_q));

endmodule
`default_nettype wire

/* File: bench/i2c_host_model.sv */
// i2c host model that reads the trim bank
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
    // clock
    input  wire logic clk,
    // i2c pins, host side, high means released
    output var  logic scl,
    output var  logic sda_h,
    input  wire logic sda
);
    // both lines released at time zero
    initial begin
        scl   = 1'b1;
        sda_h = 1'b1;
    end
    // set both pins, then hold them for one scl phase of four clocks
    task automatic pins(input logic c, input logic d);
        scl   = c;
        sda_h = d;
        repeat (4) @(negedge clk);
    endtask
    // start or repeated start, leaves scl low
    task automatic start();
        pins(scl, 1'b1);
        pins(1'b1, 1'b1);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
    endtask
    // eight bits msb first then the ack slot, sampled late in scl high
    task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                        output logic [7:0] rx, output logic ack_rx);
        logic [8:0] sh;
        sh = {tx, ack_tx};
        for (int i = 8; i >= 0; i--) begin
            pins(1'b0, sh[i]);
            pins(1'b1, sh[i]);
            if (i > 0) begin
                rx[i-1] = sda;
            end else begin
                ack_rx = sda;
            end
            pins(1'b0, sh[i]);
        end
    endtask
    // pointer write, repeated start, data and an optional crc byte, stop
    task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr,
                            input logic want_crc, output logic [7:0] data,
                            output logic [7:0] crc, output logic [2:0] acks);
        logic [7:0] junk;
        logic       host_ack;
        crc = 8'hFF;
        start();
        xfer({addr, 1'b0}, 1'b1, junk, acks[0]);
        xfer(ptr, 1'b1, junk, acks[1]);
        start();
        xfer({addr, 1'b1}, 1'b1, junk, acks[2]);
        xfer(8'hFF, ~want_crc, data, host_ack);
        if (want_crc) begin
            xfer(8'hFF, 1'b1, crc, host_ack);
        end
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
    endtask
endmodule
`default_nettype wire

/* File: bench/calibration_trim_register_bank_bench.sv */
// self-checking bench for the calibration trim register bank
`timescale 1ns/1ps
`default_nettype none
module calibration_trim_register_bank_bench;
    import trim_bank_pkg::*;
    localparam logic [6:0] DEV  = 7'h08; // arbitrary bus address
    localparam logic [7:0] POLY = 8'h07;
    // clock, reset, pins and trim image
    logic        clk;
    logic        rstn;
    logic        scl;
    logic        sda_h;
    logic        sda_out;
    logic        sda_oe;
    wire logic   sda;
    logic [19:0] off_lo;
    logic [19:0] gain_lo;
    logic [5:0]  off_msb;
    logic [5:0]  gain_msb;
    logic [2:0]  ref_bits;
    logic [7:0]  ptrs [9];
    logic [7:0]  got [9];
    int          bad_count;
    int          samples_checked;
    // open drain wire with host pull-up
    assign sda = sda_h & (sda_oe ? sda_out : 1'b1);
    // design and host model
    calibration_trim_register_bank #(.DEVICE_ADDR(DEV), .CRC_POLY(POLY))
        calibration_trim_register_bank_inst (
        .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .offset_low_in(off_lo), .gain_low_in(gain_lo),
        .offset_msb_in(off_msb), .gain_msb_in(gain_msb),
        .reference_offset_bit5(ref_bits[2]), .reference_offset_bit4(ref_bits[1]),
        .reference_gain_msb(ref_bits[0]));
    i2c_host_model i2c_host_model_inst (.clk(clk), .scl(scl), .sda_h(sda_h), .sda(sda));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // expected register contents from the trim image
    function automatic logic [7:0] exp_reg(input logic [7:0] p);
        int c;
        c = 4 * (int'(p) - int'(REG_CELL2_TRIM));
        if (p >= REG_CELL2_TRIM && p <= REG_CELL6_TRIM) return {off_lo[c+:4], gain_lo[c+:4]};
        case (p)
            REG_CELLS_1_2_MSBS: return {off_msb[0], gain_msb[0], off_msb[1], gain_msb[1], 4'h0};
            REG_CELLS_3_6_MSBS: return {off_msb[2], gain_msb[2], off_msb[3], gain_msb[3],
                                        off_msb[4], gain_msb[4], off_msb[5], gain_msb[5]};
            REG_REF_MSBS:       return {5'h00, ref_bits};
            default:            return UNMAPPED_VALUE;
        endcase
    endfunction
    // crc8 msb first over the read address byte and the data byte
    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [15:0] m;
        logic [7:0]  r;
        m = {DEV, 1'b1, d};
        r = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            r = (r[7] ^ m[i]) ? ((r << 1) ^ POLY) : (r << 1);
        end
        return r;
    endfunction
    // host assembly: extension bit above the four low bits, sign extended
    function automatic logic [7:0] sx5(input logic msb, input logic [3:0] lo);
        return {{4{msb}}, lo};
    endfunction
    // single compare point
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // counts, verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog well beyond the nineteen reads
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    // main sequence
    initial begin
        logic [7:0] d;
        logic [7:0] crc;
        logic [2:0] acks;
        bad_count = 0;
        samples_checked = 0;
        rstn = 1'b0;
        ptrs = '{REG_CELL2_TRIM, REG_CELL3_TRIM, REG_CELL4_TRIM, REG_CELL5_TRIM,
                 REG_CELL6_TRIM, REG_CELLS_1_2_MSBS, REG_CELLS_3_6_MSBS, REG_REF_MSBS, 8'h19};
        {off_lo, gain_lo, off_msb, gain_msb, ref_bits} = '0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        // every register under a pattern and its inverse, crc on alternate reads
        for (int k = 0; k < 2; k++) begin
            {off_lo, gain_lo, off_msb, gain_msb, ref_bits} =
                {20'h1E5B2, 20'h7C4A3, 6'h2D, 6'h19, 3'h5} ^ {55{k[0]}};
            for (int i = 0; i < 9; i++) begin
                i2c_host_model_inst.read_reg(DEV, ptrs[i], !i[0], d, crc, acks);
                got[i] = d;
                check("acks", {5'h00, acks}, 8'h00);
                check("data", d, exp_reg(ptrs[i]));
                if (!i[0]) begin
                    check("crc", crc, crc8(exp_reg(ptrs[i])));
                end
            end
            // signed corrections rebuilt by the host from split fields
            check("cell2 offset", sx5(got[5][5], got[0][7:4]),
                  sx5(off_msb[1], off_lo[3:0]));
            check("cell4 gain", sx5(got[6][4], got[2][3:0]),
                  sx5(gain_msb[3], gain_lo[11:8]));
            check("ref offset", {{2{got[7][2]}}, got[7][2:1], 4'h0},
                  {{2{ref_bits[2]}}, ref_bits[2:1], 4'h0});
            $display("test pattern %0d done", k);
        end
        // another bus address gets no answer
        i2c_host_model_inst.read_reg(DEV ^ 7'h01, REG_CELL2_TRIM, 1'b1, d, crc, acks);
        check("foreign acks", {5'h00, acks}, 8'h07);
        check("foreign data", d, 8'hFF);
        $display("test foreign address done");
        end_sim();
    end
endmodule
`default_nettype wire
